// ===== fifo_cfg_pkg.sv
// package: register map, field positions and reset values of the fifo engine configuration
package fifo_cfg_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [11:0] RECEIVE_CONFIG_OFFSET  = 12'h06C;
    localparam logic [11:0] TRANSMIT_CONFIG_OFFSET = 12'h070;
    localparam logic [11:0] ENGINE_STATUS_OFFSET   = 12'h078;
    localparam logic [11:0] EVENT_ENABLE_OFFSET    = 12'h07C;

    // ****************************************
    // receive_config fields
    // ****************************************
    localparam int RX_ALIGN_HI     = 31;
    localparam int RX_ALIGN_LO     = 30;
    localparam int RX_COUNT_HI     = 27;
    localparam int RX_COUNT_LO     = 16;
    localparam int RX_FLUSH_BIT    = 15;
    localparam int RX_OFFSET_HI    = 12;
    localparam int RX_OFFSET_LO    = 8;

    // ****************************************
    // transmit_config fields
    // ****************************************
    localparam int TX_STATUS_FLUSH_BIT = 15;
    localparam int TX_DATA_FLUSH_BIT   = 14;
    localparam int TX_OVERRUN_BIT      = 2;
    localparam int TX_ENABLE_BIT       = 1;
    localparam int TX_STOP_BIT         = 0;

    // ****************************************
    // event enable fields
    // ****************************************
    localparam int RX_DMA_EVENT_EN_BIT  = 20;
    localparam int TX_FULL_EVENT_EN_BIT = 8;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0]  RX_ALIGN_RESET  = 2'h0;
    localparam logic [11:0] RX_COUNT_RESET  = 12'h000;
    localparam logic [4:0]  RX_OFFSET_RESET = 5'h00;

    // end alignment codes
    localparam logic [1:0] ALIGN_4  = 2'h0;
    localparam logic [1:0] ALIGN_16 = 2'h1;
    localparam logic [1:0] ALIGN_32 = 2'h2;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SENDING,
        TX_STALLED,
        TX_HALTED
    } tx_state_t;

endpackage

// ===== rx_pad_align.sv
// receive read path: start offset insertion and end-of-buffer alignment padding
`timescale 1ns/1ps
module rx_pad_align (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        flush,
    input  wire logic [1:0]  align_sel,
    input  wire logic [4:0]  start_offset,
    input  wire logic        read_strobe,
    input  wire logic        last_word,
    output logic             pad_active,
    output logic             word_taken,
    output logic [2:0]       lead_dwords,
    output logic [1:0]       lead_bytes
);

    logic [2:0] phase_reg;
    logic [2:0] phase_next;
    logic       pad_reg;
    logic       pad_next;
    logic [2:0] mask;
    logic       aligned;

    // modulus mask for the selected boundary in dwords; reserved code falls back to 4-byte
    assign mask = (align_sel == fifo_cfg_pkg::ALIGN_16) ? 3'h3 :
                  (align_sel == fifo_cfg_pkg::ALIGN_32) ? 3'h7 : 3'h0;
    assign aligned = ((phase_reg + 3'h1) & mask) == 3'h0;
    // upper offset bits are sampled live so a change acts on the next dword read
    assign lead_dwords = start_offset[4:2];
    assign lead_bytes  = start_offset[1:0];
    assign word_taken  = read_strobe;
    assign pad_active  = pad_reg;

    // track position inside the alignment block and pad after the last data word
    always_comb begin
        phase_next = phase_reg;
        pad_next   = pad_reg;
        if (read_strobe) begin
            phase_next = (phase_reg + 3'h1) & mask;
            if (aligned) begin
                pad_next = 1'b0;
            end else if (last_word) begin
                pad_next = 1'b1;
            end
        end
        if (flush) begin
            phase_next = 3'h0;
            pad_next   = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 3'h0;
            pad_reg   <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            pad_reg   <= pad_next;
        end
    end

endmodule

// ===== tx_control.sv
// transmitter enable and graceful stop sequencer
`timescale 1ns/1ps
module tx_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        enable,
    input  wire logic        stop_req,
    input  wire logic        overrun_permit,
    input  wire logic        status_full,
    input  wire logic        data_pending,
    input  wire logic        frame_done,
    output logic             tx_go,
    output logic             halted
);

    fifo_cfg_pkg::tx_state_t state_reg;
    fifo_cfg_pkg::tx_state_t state_next;
    logic                    suspend;

    // a full status fifo stalls sending only when overrun is not permitted
    assign suspend = status_full && !overrun_permit;
    assign tx_go   = (state_reg == fifo_cfg_pkg::TX_SENDING);
    assign halted  = (state_reg == fifo_cfg_pkg::TX_HALTED);

    // a frame in flight always finishes before the stop takes hold
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            fifo_cfg_pkg::TX_IDLE: begin
                if (enable && stop_req) begin
                    state_next = fifo_cfg_pkg::TX_HALTED;
                end else if (enable && data_pending && !suspend) begin
                    state_next = fifo_cfg_pkg::TX_SENDING;
                end
            end
            fifo_cfg_pkg::TX_SENDING: begin
                if (frame_done) begin
                    state_next = stop_req ? fifo_cfg_pkg::TX_HALTED :
                                 suspend  ? fifo_cfg_pkg::TX_STALLED :
                                            fifo_cfg_pkg::TX_IDLE;
                end
            end
            fifo_cfg_pkg::TX_STALLED: begin
                if (stop_req) begin
                    state_next = fifo_cfg_pkg::TX_HALTED;
                end else if (!suspend) begin
                    state_next = fifo_cfg_pkg::TX_IDLE;
                end
            end
            fifo_cfg_pkg::TX_HALTED: begin
                state_next = fifo_cfg_pkg::TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= fifo_cfg_pkg::TX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

// ===== rx_tx_fifo_engine_config.sv
// receive and transmit configuration registers of the packet fifo engine, apb slave
// Overview of operation
// - end alignment field: 00 4-byte, 01 16-byte, 10 32-byte, 11 reserved
// - pad dwords after last transfer until chosen alignment boundary
// - 12-bit countdown of dwords read before the receive dma event
// - countdown drops one per dword read; rewrite allowed anytime
// - receive flush clears receive data and status pointers, self-clearing
// - five-bit start offset shifts packet data by 0 to 31 bytes
// - upper three offset bits may change live, act next dword read
// - transmit status flush clears status pointers, self-clearing
// - transmit data flush clears data pointers, self-clearing
// - overrun permit clear suspends sending while status fifo full
// - overrun permit never affects the status full event
// - transmitter enabled sends whatever data the fifo holds
// - enable clears itself once stop requested and transmitter halted
// - stop request finishes current frame, halts, then self-clears
// - writes to stop request ignored while it is high
// - receive dma event has own enable bit gating interrupt line
// - status full event raised when transmit status fifo becomes full
`timescale 1ns/1ps
module rx_tx_fifo_engine_config (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_dword_read,
    input  wire logic        rx_last_word,
    input  wire logic        tx_status_full,
    input  wire logic        tx_data_pending,
    input  wire logic        tx_frame_done,
    output logic             rx_flush_pulse,
    output logic             tx_status_flush,
    output logic             tx_data_flush,
    output logic             rx_pad_active,
    output logic [2:0]       rx_lead_dwords,
    output logic [1:0]       rx_lead_bytes,
    output logic             tx_go,
    output logic             rx_dma_event,
    output logic             tx_status_full_event,
    output logic             rx_dma_irq,
    output logic             tx_full_irq
);

    // ****************************************
    // apb decode
    // ****************************************
    logic        access;
    logic        wr_en;
    logic        hit_rx;
    logic        hit_tx;
    logic        hit_sts;
    logic        hit_en;
    logic        mapped;

    assign access  = psel && penable;
    assign hit_rx  = paddr == fifo_cfg_pkg::RECEIVE_CONFIG_OFFSET;
    assign hit_tx  = paddr == fifo_cfg_pkg::TRANSMIT_CONFIG_OFFSET;
    assign hit_sts = paddr == fifo_cfg_pkg::ENGINE_STATUS_OFFSET;
    assign hit_en  = paddr == fifo_cfg_pkg::EVENT_ENABLE_OFFSET;
    assign mapped  = hit_rx || hit_tx || hit_sts || hit_en;
    assign wr_en   = access && pwrite && mapped;
    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // ****************************************
    // register state
    // ****************************************
    logic [1:0]  rx_align_reg;
    logic [11:0] rx_dword_countdown_reg;
    logic [11:0] rx_dword_countdown_next;
    logic [4:0]  rx_start_offset_reg;
    logic        tx_status_overrun_permit_reg;
    logic        tx_enable_reg;
    logic        tx_enable_next;
    logic        tx_stop_reg;
    logic        tx_stop_next;
    logic        rx_dma_en_reg;
    logic        tx_full_en_reg;
    logic        rx_dma_event_reg;
    logic        full_seen_reg;
    logic        tx_full_event_reg;
    logic        rx_flush_reg;
    logic        txs_flush_reg;
    logic        txd_flush_reg;
    logic [31:0] prdata_reg;
    logic        tx_halted;
    logic        wr_rx;
    logic        wr_tx;
    logic        count_hits_zero;

    assign wr_rx = wr_en && hit_rx;
    assign wr_tx = wr_en && hit_tx;

    // countdown: a host write wins over a decrement in the same cycle
    assign count_hits_zero = rx_dword_read && (rx_dword_countdown_reg == 12'h001) && !wr_rx;
    assign rx_dword_countdown_next =
        wr_rx ? pwdata[fifo_cfg_pkg::RX_COUNT_HI:fifo_cfg_pkg::RX_COUNT_LO] :
        (rx_dword_read && rx_dword_countdown_reg != 12'h000) ?
            rx_dword_countdown_reg - 12'h001 : rx_dword_countdown_reg;

    // stop bit: writes ignored while high, clears when the transmitter halts
    assign tx_stop_next =
        tx_halted ? 1'b0 :
        tx_stop_reg ? 1'b1 :
        wr_tx ? pwdata[fifo_cfg_pkg::TX_STOP_BIT] : 1'b0;
    assign tx_enable_next =
        tx_halted ? 1'b0 :
        wr_tx ? pwdata[fifo_cfg_pkg::TX_ENABLE_BIT] : tx_enable_reg;

    // configuration fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_align_reg                 <= fifo_cfg_pkg::RX_ALIGN_RESET;
            rx_start_offset_reg          <= fifo_cfg_pkg::RX_OFFSET_RESET;
            tx_status_overrun_permit_reg <= 1'b0;
            rx_dma_en_reg                <= 1'b0;
            tx_full_en_reg               <= 1'b0;
        end else begin
            if (wr_rx) begin
                rx_align_reg        <= pwdata[fifo_cfg_pkg::RX_ALIGN_HI:fifo_cfg_pkg::RX_ALIGN_LO];
                rx_start_offset_reg <= pwdata[fifo_cfg_pkg::RX_OFFSET_HI:fifo_cfg_pkg::RX_OFFSET_LO];
            end
            if (wr_tx) begin
                tx_status_overrun_permit_reg <= pwdata[fifo_cfg_pkg::TX_OVERRUN_BIT];
            end
            if (wr_en && hit_en) begin
                rx_dma_en_reg  <= pwdata[fifo_cfg_pkg::RX_DMA_EVENT_EN_BIT];
                tx_full_en_reg <= pwdata[fifo_cfg_pkg::TX_FULL_EVENT_EN_BIT];
            end
        end
    end

    // countdown, transmit control bits and self-clearing flush pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_dword_countdown_reg <= fifo_cfg_pkg::RX_COUNT_RESET;
            tx_enable_reg          <= 1'b0;
            tx_stop_reg            <= 1'b0;
            rx_flush_reg           <= 1'b0;
            txs_flush_reg          <= 1'b0;
            txd_flush_reg          <= 1'b0;
        end else begin
            rx_dword_countdown_reg <= rx_dword_countdown_next;
            tx_enable_reg          <= tx_enable_next;
            tx_stop_reg            <= tx_stop_next;
            rx_flush_reg  <= wr_rx && pwdata[fifo_cfg_pkg::RX_FLUSH_BIT];
            txs_flush_reg <= wr_tx && pwdata[fifo_cfg_pkg::TX_STATUS_FLUSH_BIT];
            txd_flush_reg <= wr_tx && pwdata[fifo_cfg_pkg::TX_DATA_FLUSH_BIT];
        end
    end

    // events: one-cycle pulses; the full event ignores the overrun permit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_dma_event_reg  <= 1'b0;
            full_seen_reg     <= 1'b0;
            tx_full_event_reg <= 1'b0;
        end else begin
            rx_dma_event_reg  <= count_hits_zero;
            full_seen_reg     <= tx_status_full;
            tx_full_event_reg <= tx_status_full && !full_seen_reg;
        end
    end

    assign rx_flush_pulse       = rx_flush_reg;
    assign tx_status_flush      = txs_flush_reg;
    assign tx_data_flush        = txd_flush_reg;
    assign rx_dma_event         = rx_dma_event_reg;
    assign tx_status_full_event = tx_full_event_reg;
    assign rx_dma_irq           = rx_dma_event_reg && rx_dma_en_reg;
    assign tx_full_irq          = tx_full_event_reg && tx_full_en_reg;

    // ****************************************
    // read path
    // ****************************************
    logic [31:0] rd_rx;
    logic [31:0] rd_tx;
    logic [31:0] rd_sts;
    logic [31:0] rd_en;
    logic [31:0] rd_mux;

    // reserved and flush bits read back as zero
    assign rd_rx  = {rx_align_reg, 2'h0, rx_dword_countdown_reg, 3'h0, rx_start_offset_reg, 8'h00};
    assign rd_tx  = {29'h00000000, tx_status_overrun_permit_reg, tx_enable_reg, tx_stop_reg};
    assign rd_sts = {28'h0000000, rx_pad_active, tx_halted, tx_go, tx_status_full};
    assign rd_en  = {11'h000, rx_dma_en_reg, 11'h000, tx_full_en_reg, 8'h00};
    assign rd_mux = hit_rx ? rd_rx : hit_tx ? rd_tx : hit_sts ? rd_sts : hit_en ? rd_en : 32'h00000000;

    // read data registered in the setup cycle so it is stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end
    assign prdata = prdata_reg;

    // ****************************************
    // sub-blocks
    // ****************************************
    rx_pad_align u_rx_pad_align (
        .pclk         (pclk),
        .presetn      (presetn),
        .flush        (rx_flush_reg),
        .align_sel    (rx_align_reg),
        .start_offset (rx_start_offset_reg),
        .read_strobe  (rx_dword_read),
        .last_word    (rx_last_word),
        .pad_active   (rx_pad_active),
        .word_taken   (),
        .lead_dwords  (rx_lead_dwords),
        .lead_bytes   (rx_lead_bytes)
    );

    tx_control u_tx_control (
        .pclk           (pclk),
        .presetn        (presetn),
        .enable         (tx_enable_reg),
        .stop_req       (tx_stop_reg),
        .overrun_permit (tx_status_overrun_permit_reg),
        .status_full    (tx_status_full),
        .data_pending   (tx_data_pending),
        .frame_done     (tx_frame_done),
        .tx_go          (tx_go),
        .halted         (tx_halted)
    );

endmodule

// ===== tx_path_model.sv
// far-side model: transmit datapath that sends queued frames while the block lets it
`timescale 1ns/1ps
module tx_path_model #(
    parameter int FRAME_LEN = 20
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic tx_go,
    input  wire logic load,
    output logic      tx_data_pending,
    output logic      tx_frame_done
);
    logic [7:0] frames_reg;
    logic [7:0] beat_reg;

    // frame pacing; long frames so a stop request lands mid-frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_reg    <= 8'h00;
            beat_reg      <= 8'h00;
            tx_frame_done <= 1'b0;
        end else begin
            tx_frame_done <= 1'b0;
            if (load) begin
                frames_reg <= 8'h14;
            end else if (tx_go && frames_reg != 8'h00) begin
                if (beat_reg == 8'(FRAME_LEN - 1)) begin
                    beat_reg      <= 8'h00;
                    frames_reg    <= frames_reg - 8'h01;
                    tx_frame_done <= 1'b1;
                end else begin
                    beat_reg <= beat_reg + 8'h01;
                end
            end
        end
    end

    assign tx_data_pending = frames_reg != 8'h00;
endmodule

// ===== fifo_cfg_checker.sv
// checker: apb error answer, self-clearing pulses, offset split and event gating
`timescale 1ns/1ps
module fifo_cfg_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        rx_dword_read,
    input wire logic        tx_status_full,
    input wire logic        rx_flush_pulse,
    input wire logic        tx_status_flush,
    input wire logic        tx_data_flush,
    input wire logic [2:0]  rx_lead_dwords,
    input wire logic [1:0]  rx_lead_bytes,
    input wire logic        rx_dma_event,
    input wire logic        tx_status_full_event,
    input wire logic        rx_dma_irq,
    input wire logic        tx_full_irq
);
    // ****************
    // committed write decode
    // ****************
    wire       rx_wr = psel && penable && pwrite && paddr == fifo_cfg_pkg::RECEIVE_CONFIG_OFFSET;
    wire       tx_wr = psel && penable && pwrite && paddr == fifo_cfg_pkg::TRANSMIT_CONFIG_OFFSET;
    wire       rx_flush_req = rx_wr && pwdata[fifo_cfg_pkg::RX_FLUSH_BIT];
    wire [4:0] wr_offset = pwdata[12:8];
    wire       mapped = paddr == fifo_cfg_pkg::RECEIVE_CONFIG_OFFSET || paddr == fifo_cfg_pkg::TRANSMIT_CONFIG_OFFSET
                     || paddr == fifo_cfg_pkg::ENGINE_STATUS_OFFSET || paddr == fifo_cfg_pkg::EVENT_ENABLE_OFFSET;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a flush is exactly one cycle wide, so a stuck pulse shows
    sequence one_shot(sig);
        sig ##1 !sig;
    endsequence

    unmapped_error_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("error answer wrong for address");
    rx_flush_a: assert property (rx_flush_req |=> one_shot(rx_flush_pulse))
        else $error("receive flush pulse missing");
    rx_flush_cause_a: assert property (rx_flush_pulse |-> $past(rx_flush_req))
        else $error("receive flush without request");
    tx_sflush_a: assert property (tx_wr && pwdata[15] |=> one_shot(tx_status_flush))
        else $error("status flush pulse missing");
    tx_dflush_a: assert property (tx_wr && pwdata[14] |=> one_shot(tx_data_flush))
        else $error("data flush pulse missing");
    offset_split_a: assert property (rx_wr |=> {rx_lead_dwords, rx_lead_bytes} == $past(wr_offset))
        else $error("start offset split wrong");
    offset_hold_a: assert property (!rx_wr |=> $stable(rx_lead_dwords) && $stable(rx_lead_bytes))
        else $error("start offset moved without write");
    full_event_a: assert property ($rose(tx_status_full) |=> tx_status_full_event)
        else $error("status full event missing");
    dma_cause_a: assert property (rx_dma_event |-> $past(rx_dword_read))
        else $error("dma event without dword read");
    irq_gate_a: assert property (rx_dma_irq |-> rx_dma_event)
        else $error("dma irq without event");
    full_gate_a: assert property (tx_full_irq |-> tx_status_full_event)
        else $error("full irq without event");
endmodule

bind rx_tx_fifo_engine_config fifo_cfg_checker u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .rx_dword_read(rx_dword_read), .tx_status_full(tx_status_full), .rx_flush_pulse(rx_flush_pulse),
    .tx_status_flush(tx_status_flush), .tx_data_flush(tx_data_flush), .rx_lead_dwords(rx_lead_dwords),
    .rx_lead_bytes(rx_lead_bytes), .rx_dma_event(rx_dma_event), .tx_status_full_event(tx_status_full_event),
    .rx_dma_irq(rx_dma_irq), .tx_full_irq(tx_full_irq));

// ===== tb_rx_tx_fifo_engine_config.sv
// testbench: register access, receive countdown and padding, transmit stop sequence
`timescale 1ns/1ps
module tb_rx_tx_fifo_engine_config;
    localparam logic [11:0] RXC = fifo_cfg_pkg::RECEIVE_CONFIG_OFFSET;
    localparam logic [11:0] TXC = fifo_cfg_pkg::TRANSMIT_CONFIG_OFFSET;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        rx_dword_read = 1'b0;
    logic        rx_last_word = 1'b0;
    logic        tx_status_full = 1'b0;
    logic        load = 1'b0;
    logic [31:0] prdata;
    logic [2:0]  rx_lead_dwords;
    logic [1:0]  rx_lead_bytes;
    logic        pready, pslverr, tx_data_pending, tx_frame_done, tx_go, rx_pad_active;
    logic        rx_dma_event, tx_status_full_event, rx_dma_irq, tx_full_irq;
    logic [32:0] exp_q[$];
    logic [31:0] d;
    int          seed, failures, compares, dma_n, irq_n, full_n, fi_n, n;
    int          pad_exp[3] = '{0, 1, 5};

    rx_tx_fifo_engine_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_dword_read(rx_dword_read), .rx_last_word(rx_last_word), .tx_status_full(tx_status_full),
        .tx_data_pending(tx_data_pending), .tx_frame_done(tx_frame_done), .rx_flush_pulse(),
        .tx_status_flush(), .tx_data_flush(), .rx_pad_active(rx_pad_active), .rx_lead_dwords(rx_lead_dwords),
        .rx_lead_bytes(rx_lead_bytes), .tx_go(tx_go), .rx_dma_event(rx_dma_event),
        .tx_status_full_event(tx_status_full_event), .rx_dma_irq(rx_dma_irq), .tx_full_irq(tx_full_irq));

    tx_path_model #(.FRAME_LEN(20)) u_path (.pclk(pclk), .presetn(presetn), .tx_go(tx_go), .load(load),
        .tx_data_pending(tx_data_pending), .tx_frame_done(tx_frame_done));

    // 10 MHz clock
    always #50 pclk = ~pclk;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // one apb transfer; a read leaves its expected {pslverr, prdata} for the monitor
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
        int k;
        k = 0;
        if (!w) exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            failures++;
            close_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // host reads of receive dwords, one cycle strobe then one idle
    task automatic rd(input int cnt, input logic last);
        repeat (cnt) begin
            rx_dword_read <= 1'b1;
            rx_last_word <= last;
            @(posedge pclk);
            rx_dword_read <= 1'b0;
            rx_last_word <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic wait_go(input logic v);
        int k;
        k = 0;
        while (tx_go !== v && k < 100) begin
            @(posedge pclk);
            k++;
        end
        check({32'h0, tx_go}, {32'h0, v});
        if (k >= 100) close_out();
    endtask

    // ****************
    // monitor: read answers and event counts
    // ****************
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            check({pslverr, prdata}, exp_q.pop_front());
        if (rx_dma_event === 1'b1) dma_n++;
        if (rx_dma_irq === 1'b1) irq_n++;
        if (tx_status_full_event === 1'b1) full_n++;
        if (tx_full_irq === 1'b1) fi_n++;
    end

    // watchdog keeps a hang from running forever
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        close_out();
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        seed = 32'h25D32253;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, RXC, 32'h0, 33'h0);
        apb(1'b0, TXC, 32'h0, 33'h0);
        apb(1'b0, 12'h080, 32'h0, {1'b1, 32'h0});
        repeat (4) begin
            d = $random(seed);
            d[31] = 1'b0;
            d[15] = 1'b0;
            apb(1'b1, RXC, d, 33'h0);
            apb(1'b0, RXC, 32'h0, {1'b0, d & 32'hCFFF_1F00});
            d = $random(seed);
            d[15:14] = 2'b11;
            d[1:0] = 2'b00;
            apb(1'b1, TXC, d, 33'h0);
            apb(1'b0, TXC, 32'h0, {1'b0, d & 32'h0000_0004});
        end
        apb(1'b1, TXC, 32'h0, 33'h0);
        apb(1'b1, fifo_cfg_pkg::EVENT_ENABLE_OFFSET, 32'h0010_0100, 33'h0);
        // countdown with a mid-way reload; only the final read fires
        apb(1'b1, RXC, 32'h0003_8000, 33'h0);
        rd(1, 1'b0);
        apb(1'b0, RXC, 32'h0, {1'b0, 32'h0002_0000});
        apb(1'b1, RXC, 32'h0005_0000, 33'h0);
        rd(4, 1'b0);
        check(33'(dma_n), 33'h0);
        rd(1, 1'b0);
        @(posedge pclk);
        check(33'(dma_n), 33'h1);
        check(33'(irq_n), 33'h1);
        // live change of whole-dword offset only, low bits kept
        apb(1'b1, RXC, 32'h0000_1B00, 33'h0);
        apb(1'b1, RXC, 32'h0000_0700, 33'h0);
        check({28'h0, rx_lead_dwords, rx_lead_bytes}, 33'h07);
        // alignment set between packets; three-dword packet per code
        for (int a = 0; a < 3; a++) begin
            apb(1'b1, RXC, {a[1:0], 30'h0000_8000}, 33'h0);
            rd(2, 1'b0);
            rd(1, 1'b1);
            n = 0;
            while (rx_pad_active === 1'b1 && n < 9) begin
                rd(1, 1'b0);
                n++;
            end
            check(33'(n), 33'(pad_exp[a]));
            if (n >= 9) close_out();
        end
        // transmit: send, stall on full, permit overrun, then graceful stop
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
        apb(1'b1, TXC, 32'h2, 33'h0);
        wait_go(1'b1);
        tx_status_full <= 1'b1;
        wait_go(1'b0);
        apb(1'b1, TXC, 32'h6, 33'h0);
        wait_go(1'b1);
        tx_status_full <= 1'b0;
        repeat (2) @(posedge pclk);
        tx_status_full <= 1'b1;
        repeat (3) @(posedge pclk);
        check({32'h0, tx_go}, 33'h1);
        tx_status_full <= 1'b0;
        check(33'(full_n), 33'h2);
        check(33'(fi_n), 33'h2);
        apb(1'b1, TXC, 32'h7, 33'h0);
        apb(1'b1, TXC, 32'h6, 33'h0);
        wait_go(1'b0);
        repeat (3) @(posedge pclk);
        apb(1'b0, TXC, 32'h0, {1'b0, 32'h4});
        close_out();
    end
endmodule
